/* File: rtl/input_divider.sv */
// module: instruction clock prescaler giving divide by 1, 4 or 16
`timescale 1ns/1ns
module input_divider #(
  parameter int DIV_WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input_divider_if.divider link
);
  import timer_two_pkg::*;

  typedef struct packed {
    logic [DIV_WIDTH-1:0] cnt;
  } divider_state_type;

  divider_state_type state_q;
  divider_state_type state_d;
  logic [DIV_WIDTH-1:0] terminal;

  // the counter must reach 15 for the divide by sixteen setting
  if (DIV_WIDTH < 4) begin : g_width_check
    $error("input_divider: DIV_WIDTH must be at least 4");
  end

  // terminal count per select code; either code with the upper bit set is /16
  always_comb begin
    unique case (link.select)
      INPUT_DIV_BY_1: terminal = DIV_WIDTH'(TERMINAL_DIV_1);
      INPUT_DIV_BY_4: terminal = DIV_WIDTH'(TERMINAL_DIV_4);
      default: terminal = DIV_WIDTH'(TERMINAL_DIV_16);
    endcase
  end

  // tick is the last cycle of each division window, only while running
  assign link.tick = link.run && (state_q.cnt == terminal);

  // count while running; a clear restarts the window
  always_comb begin
    state_d = state_q;
    if (link.clear) begin
      state_d.cnt = '0;
    end else if (link.run) begin
      if (state_q.cnt == terminal) begin
        state_d.cnt = '0;
      end else begin
        state_d.cnt = state_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end
endmodule

/* File: rtl/input_divider_if.sv */
// interface: link between the timer core and its input divider
`timescale 1ns/1ns
interface input_divider_if;
  logic [1:0] select;
  logic run;
  logic clear;
  logic tick;

  modport core (output select, output run, output clear, input tick);
  modport divider (input select, input run, input clear, output tick);
endinterface

/* File: rtl/period_timer.sv */
// module: 8-bit period timer with prescaler, postscaler and apb registers
//
// Notes on behaviour
// - An 8-bit count register is readable and writable and clears to zero on any reset.
// - The count input is pclk divided by 1 (select 00), 4 (01) or 16 (upper bit set).
// - The count rises from zero to the period value, then returns to zero on the next tick.
// - The period register is readable and writable and resets to all ones.
// - Matches pass a 4-bit postscaler whose terminal count sets the match flag (flags bit 1).
// - The postscaler gives one flag per select-plus-one matches, 1 to 16.
// - The counter advances only while the run bit (control bit 2) is one.
// - Writes to count or control, and any reset, clear both scaler counters.
// - A control write leaves the count value unchanged.
// - The match pulse ahead of the postscaler goes out for the serial port shift clock.
// - The count and match are also exported as the pwm time base.
// - Control bit 7 is not implemented, reads as zero and ignores writes.
`timescale 1ns/1ns
module period_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_two_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [timer_two_pkg::DATA_WIDTH-1:0] pwdata,
  output logic [timer_two_pkg::DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic period_match,
  output logic [timer_two_pkg::REG_WIDTH-1:0] time_base,
  output logic match_irq
);
  import timer_two_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [REG_WIDTH-1:0] count;
    logic [CTRL_IMPL_WIDTH-1:0] control;
    logic [REG_WIDTH-1:0] period;
    logic [3:0] post;
    logic match_flag;
    logic match_irq_enable;
    logic match;
    logic irq;
    logic ready;
    logic err;
    logic [DATA_WIDTH-1:0] rdata;
  } timer_state_type;

  localparam timer_state_type RESET_STATE = '{
    count: RESET_COUNT,
    control: RESET_CONTROL,
    period: RESET_PERIOD,
    post: RESET_POSTSCALE,
    match_flag: 1'b0,
    match_irq_enable: 1'b0,
    match: 1'b0,
    irq: 1'b0,
    ready: 1'b0,
    err: 1'b0,
    rdata: '0
  };

  timer_state_type state_q;
  timer_state_type state_d;

  // byte addresses of the five registers
  localparam logic [ADDR_WIDTH-1:0] ADDR_FLAGS =
    ADDR_WIDTH'({IDX_PERIPHERAL_FLAGS, 2'b00});
  localparam logic [ADDR_WIDTH-1:0] ADDR_COUNT =
    ADDR_WIDTH'({IDX_TIMER_TWO_COUNT, 2'b00});
  localparam logic [ADDR_WIDTH-1:0] ADDR_CONTROL =
    ADDR_WIDTH'({IDX_TIMER_TWO_CONTROL, 2'b00});
  localparam logic [ADDR_WIDTH-1:0] ADDR_ENABLES =
    ADDR_WIDTH'({IDX_PERIPHERAL_IRQ_ENABLES, 2'b00});
  localparam logic [ADDR_WIDTH-1:0] ADDR_PERIOD =
    ADDR_WIDTH'({IDX_PERIOD_LIMIT, 2'b00});

  // ==========================================================================
  // bus decode
  logic setup_phase;
  logic write_taken;
  logic hit_flags;
  logic hit_count;
  logic hit_control;
  logic hit_enables;
  logic hit_period;
  logic hit_any;
  logic [REG_WIDTH-1:0] wbyte;

  // access completes on the single cycle after setup, so pready is a flop
  assign setup_phase = psel && !penable;
  assign write_taken = psel && penable && state_q.ready && pwrite;
  assign hit_flags = (paddr == ADDR_FLAGS);
  assign hit_count = (paddr == ADDR_COUNT);
  assign hit_control = (paddr == ADDR_CONTROL);
  assign hit_enables = (paddr == ADDR_ENABLES);
  assign hit_period = (paddr == ADDR_PERIOD);
  assign hit_any = hit_flags || hit_count || hit_control || hit_enables || hit_period;
  assign wbyte = pwdata[REG_WIDTH-1:0];

  // ==========================================================================
  // divider link
  input_divider_if div_link ();

  // a write to count or control restarts the prescaler window
  assign div_link.select = state_q.control[CTRL_INPUT_DIV_LSB +: 2];
  assign div_link.run = state_q.control[CTRL_RUN_BIT];
  assign div_link.clear = write_taken && hit_any && (hit_count || hit_control);

  input_divider #(
    .DIV_WIDTH(4)
  ) u_input_divider (
    .pclk(pclk),
    .presetn(presetn),
    .link(div_link)
  );

  // ==========================================================================
  // next state
  logic at_period;
  logic post_done;

  assign at_period = (state_q.count == state_q.period);
  assign post_done = (state_q.post == state_q.control[CTRL_OUTPUT_DIV_LSB +: 4]);

  always_comb begin
    state_d = state_q;
    state_d.match = 1'b0;

    // bus answer: read data is sampled in the setup cycle, answer in the next
    state_d.ready = setup_phase;
    state_d.err = setup_phase && !hit_any;
    state_d.rdata = '0;
    if (setup_phase && !pwrite) begin
      if (hit_flags) begin
        state_d.rdata[MATCH_BIT] = state_q.match_flag;
      end else if (hit_count) begin
        state_d.rdata[REG_WIDTH-1:0] = state_q.count;
      end else if (hit_control) begin
        state_d.rdata[CTRL_IMPL_WIDTH-1:0] = state_q.control;
      end else if (hit_enables) begin
        state_d.rdata[MATCH_BIT] = state_q.match_irq_enable;
      end else if (hit_period) begin
        state_d.rdata[REG_WIDTH-1:0] = state_q.period;
      end
    end

    // counting on each prescaler tick while running
    if (div_link.tick) begin
      if (at_period) begin
        state_d.count = '0;
        state_d.match = 1'b1;
        if (post_done) begin
          state_d.post = '0;
        end else begin
          state_d.post = state_q.post + 1'b1;
        end
      end else begin
        state_d.count = state_q.count + 1'b1;
      end
    end

    // software writes; the top control bit is simply not stored
    if (write_taken) begin
      if (hit_count) begin
        state_d.count = wbyte;
        state_d.post = '0;
      end
      if (hit_control) begin
        state_d.control = wbyte[CTRL_IMPL_WIDTH-1:0];
        state_d.post = '0;
      end
      if (hit_period) begin
        state_d.period = wbyte;
      end
      if (hit_enables) begin
        state_d.match_irq_enable = wbyte[MATCH_BIT];
      end
      if (hit_flags) begin
        state_d.match_flag = wbyte[MATCH_BIT];
      end
    end

    // a postscaler completion in the same cycle as a clear still sets the flag
    if (div_link.tick && at_period && post_done) begin
      state_d.match_flag = 1'b1;
    end

    // irq follows the flag and enable as they will be after this edge
    state_d.irq = state_d.match_flag && state_d.match_irq_enable;
  end

  // ==========================================================================
  // registers; async reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs straight from flops
  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.err;
  assign period_match = state_q.match;
  assign time_base = state_q.count;
  assign match_irq = state_q.irq;
endmodule

/* File: rtl/timer_two_pkg.sv */
// package: register map, field layout and reset values of the period timer
package timer_two_pkg;

  // ==========================================================================
  // register indices as printed; byte address on the bus is four times these
  localparam logic [9:0] IDX_PERIPHERAL_FLAGS = 10'h00c;
  localparam logic [9:0] IDX_TIMER_TWO_COUNT = 10'h011;
  localparam logic [9:0] IDX_TIMER_TWO_CONTROL = 10'h012;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08c;
  localparam logic [9:0] IDX_PERIOD_LIMIT = 10'h092;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int REG_WIDTH = 8;
  localparam int WORD_SHIFT = 2;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [7:0] RESET_PERIOD = 8'hff;
  localparam logic [6:0] RESET_CONTROL = 7'h00;
  localparam logic [3:0] RESET_POSTSCALE = 4'h0;

  // ==========================================================================
  // control register fields
  localparam int CTRL_INPUT_DIV_LSB = 0;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_OUTPUT_DIV_LSB = 3;
  localparam int CTRL_IMPL_WIDTH = 7;

  // flag and enable bit inside the shared flag/enable registers
  localparam int MATCH_BIT = 1;

  // ==========================================================================
  // input divider select codes and the terminal count of each
  localparam logic [1:0] INPUT_DIV_BY_1 = 2'h0;
  localparam logic [1:0] INPUT_DIV_BY_4 = 2'h1;
  localparam logic [3:0] TERMINAL_DIV_1 = 4'h0;
  localparam logic [3:0] TERMINAL_DIV_4 = 4'h3;
  localparam logic [3:0] TERMINAL_DIV_16 = 4'hf;

endpackage

/* File: verification/period_timer_properties.sv */
// checker: bus and timer properties of the period timer
`timescale 1ns/1ns
module period_timer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_two_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [timer_two_pkg::DATA_WIDTH-1:0] pwdata,
  input wire logic [timer_two_pkg::DATA_WIDTH-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic period_match,
  input wire logic [timer_two_pkg::REG_WIDTH-1:0] time_base,
  input wire logic match_irq
);
  import timer_two_pkg::*;
  logic wr;
  logic cnt_wr;
  logic run_q;
  logic en_q;
  assign wr = psel && penable && pwrite && pready;
  assign cnt_wr = wr && paddr == 12'h044;
  // ==========================================
  // mirror of run and enable bits, as software last wrote them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      if (wr && paddr == 12'h048) run_q <= pwdata[CTRL_RUN_BIT];
      if (wr && paddr == 12'h230) en_q <= pwdata[MATCH_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // properties
  property p_ready; psel && !penable |=> pready; endproperty
  property p_err;
    pready |-> pslverr == !(paddr inside {12'h030, 12'h044, 12'h048, 12'h230, 12'h248});
  endproperty
  property p_bits;
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000 && !(paddr == 12'h048 && prdata[7]);
  endproperty
  // writes land a cycle or two before the count shows them
  property p_step;
    $changed(time_base) && !$past(cnt_wr) && !$past(cnt_wr, 2)
      |-> time_base == 8'($past(time_base) + 8'h01) || time_base == 8'h00;
  endproperty
  property p_wrap;
    period_match && !$past(cnt_wr) && !$past(cnt_wr, 2) |-> time_base == 8'h00;
  endproperty
  property p_stop;
    !run_q && !$past(run_q) && !$past(cnt_wr) && !$past(cnt_wr, 2) |-> $stable(time_base);
  endproperty
  property p_gate; match_irq |-> en_q || $past(en_q); endproperty
  property p_hold; $fell(match_irq) |-> $past(wr) || $past(wr, 2); endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_err: assert property (p_err) else $error("error flag wrong for address");
  a_bits: assert property (p_bits) else $error("unused read bits set");
  a_step: assert property (p_step) else $error("count jumped");
  a_wrap: assert property (p_wrap) else $error("match without wrap");
  a_stop: assert property (p_stop) else $error("count moved while stopped");
  a_gate: assert property (p_gate) else $error("irq while disabled");
  a_hold: assert property (p_hold) else $error("irq dropped by itself");
  c_match: cover property (period_match);
  c_irq: cover property ($rose(match_irq));
  c_err: cover property (pready && pslverr);
endmodule
bind period_timer period_timer_properties u_period_timer_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .period_match, .time_base,
  .match_irq);

/* File: verification/period_timer_tb_top.sv */
// testbench: register and timer scenarios for the period timer
`timescale 1ns/1ns
module period_timer_tb_top;
  import timer_two_pkg::*;
  localparam logic [11:0] A_FLG = 12'(IDX_PERIPHERAL_FLAGS << WORD_SHIFT);
  localparam logic [11:0] A_CNT = 12'(IDX_TIMER_TWO_COUNT << WORD_SHIFT);
  localparam logic [11:0] A_CTL = 12'(IDX_TIMER_TWO_CONTROL << WORD_SHIFT);
  localparam logic [11:0] A_EN = 12'(IDX_PERIPHERAL_IRQ_ENABLES << WORD_SHIFT);
  localparam logic [11:0] A_PER = 12'(IDX_PERIOD_LIMIT << WORD_SHIFT);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_WIDTH-1:0] paddr = '0;
  logic [DATA_WIDTH-1:0] pwdata = '0;
  logic [DATA_WIDTH-1:0] prdata;
  logic [DATA_WIDTH-1:0] rd;
  logic [REG_WIDTH-1:0] time_base;
  logic pready, pslverr, period_match, match_irq, err;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  int dv[4] = '{1, 4, 16, 16};
  int ps[3] = '{0, 1, 15};
  always #5 pclk = ~pclk;
  period_timer u_period_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .period_match, .time_base, .match_irq);
  // ==========================================
  // helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // an idle edge first, so back-to-back calls never reassign psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic next_match(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (period_match !== 1'b1 && c < 300);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge pclk);
    check("match_irq", 32'(exp), 32'(match_irq));
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #500_000;
    error_cnt++;
    finish_test;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_FLG, 32'h0000_0000);
    rchk(A_CNT, 32'h0000_0000);
    rchk(A_CTL, 32'h0000_0000);
    rchk(A_EN, 32'h0000_0000);
    rchk(A_PER, 32'h0000_00ff);
    $display("test reset_values done");
    apb(1'b1, A_PER, 32'h0000_0003);
    rchk(A_PER, 32'h0000_0003);
    apb(1'b1, A_CTL, 32'h0000_00f8);
    rchk(A_CTL, 32'h0000_0078);
    apb(1'b1, A_CNT, 32'h0000_002a);
    rchk(A_CNT, 32'h0000_002a);
    apb(1'b1, A_CTL, 32'h0000_0003);
    rchk(A_CNT, 32'h0000_002a);
    repeat (40) @(posedge pclk);
    rchk(A_CNT, 32'h0000_002a);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("slverr", 32'h0000_0001, 32'(err));
    check("unmapped", 32'h0000_0000, rd);
    $display("test registers done");
    // match spacing is (period + 1) times the input divide
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_CNT, 32'h0000_0000);
      apb(1'b1, A_CTL, 32'(i) | 32'h0000_0004);
      next_match(n);
      next_match(n);
      check("match gap", 32'(4 * dv[i]), 32'(n));
    end
    // stop the timer, load a count and watch the pwm time base port follow it
    apb(1'b1, A_CTL, 32'h0000_0000);
    apb(1'b1, A_CNT, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check("time_base", 32'h0000_0002, 32'(time_base));
    $display("test dividers done");
    apb(1'b1, A_EN, 32'h0000_0002);
    foreach (ps[i]) begin
      apb(1'b1, A_CTL, 32'h0000_0000);
      apb(1'b1, A_FLG, 32'h0000_0000);
      irq_chk(1'b0);
      apb(1'b1, A_CTL, 32'(ps[i] << 3) | 32'h0000_0004);
      n = 0;
      for (int c = 0; c < 400 && match_irq !== 1'b1; c++) begin
        @(posedge pclk);
        n += int'(period_match === 1'b1);
      end
      repeat (2) @(posedge pclk) n += int'(period_match === 1'b1);
      check("matches per flag", 32'(ps[i] + 1), 32'(n));
    end
    apb(1'b1, A_CTL, 32'h0000_0000);
    irq_chk(1'b1);
    rchk(A_FLG, 32'h0000_0002);
    apb(1'b1, A_EN, 32'h0000_0000);
    irq_chk(1'b0);
    apb(1'b1, A_EN, 32'h0000_0002);
    irq_chk(1'b1);
    apb(1'b1, A_FLG, 32'h0000_0000);
    irq_chk(1'b0);
    $display("test postscaler done");
    finish_test;
  end
endmodule
